// *** hdl/serializer_defines.svh ***
`ifndef SERIALIZER_DEFINES_SVH
`define SERIALIZER_DEFINES_SVH

// frame lengths in bits
`define FRAME_LEN_LONG      5'h10
`define FRAME_LEN_SHORT     5'h08
`define BIT_CNT_W           5

// level of the select pin that picks the long frame
`define LONG_FRAME_LEVEL    1'b0

// field positions of the long frame
`define POS_STATES_HI       15
`define POS_STATES_LO       8
`define POS_UVA             7
`define POS_OTA             6
`define POS_PC1             5
`define POS_PC4             2
`define POS_STOP_LOW        1
`define POS_STOP_HIGH       0

// fixed stop bit levels
`define STOP_LOW_VAL        1'b0
`define STOP_HIGH_VAL       1'b1

// alarm reset levels (inactive)
`define ALARM_RESET_N       1'b1

// width of the parity source field: states, alarms
`define PARITY_SRC_W        10
`define PARITY_CNT          4

// reset values
`define WORD_RESET          16'h0000
`define STATES_RESET        8'h00

`endif

// *** hdl/serializer_pkg.sv ***
package serializer_pkg;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic       mosi;
    logic       frame_length_select_pin;
    logic       bus_below_on;
    logic       bus_above_off;
    logic       temp_above_on;
    logic       temp_below_off;
    logic       bus_below_por;
    logic       vdd_below_por;
    logic [7:0] input_states;
  } pin_bundle_t;

  // one transmitted long frame, first bit on top
  typedef struct packed {
    logic [7:0] input_states;
    logic       bus_undervoltage_alarm_n;
    logic       overtemperature_alarm_n;
    logic [3:0] parity;
    logic       stop_low;
    logic       stop_high;
  } frame_word_t;

  // data-out drive for one pin pair
  typedef struct packed {
    logic miso;
    logic miso_oe_n;
    logic miso_n;
    logic miso_n_oe_n;
  } out_drive_t;

  typedef enum logic [1:0] {
    LINK_IDLE   = 2'b00,
    LINK_ACTIVE = 2'b01
  } link_state_t;

endpackage

// *** hdl/sample_fifo.sv ***
`include "serializer_defines.svh"

// snapshot fifo between the input filters and the serializer
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("sample_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             ready_next;
  logic             push;
  logic             pop;

  always_comb begin
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    wr_next    = push ? wr_reg + 1'b1 : wr_reg;
    rd_next    = pop ? rd_reg + 1'b1 : rd_reg;
    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    ready_next = count_next != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
      in_ready  <= 1'b1;
    end else begin
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      count_reg <= count_next;
      in_ready  <= ready_next;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  assign out_valid = count_reg != '0;
  assign out_data  = mem_reg[rd_reg];

endmodule

// *** hdl/digital_input_spi_serializer.sv ***
// Function
// - frame runs from chip select low to high; input states load at start
// - data-out shows the first bit at once when chip select falls
// - serial input sampled on each rising serial clock edge, mode 0
// - each falling serial clock edge shifts and drives next bit, msb first
// - select pin level picks 8 or 16 bit frame; 16 carries status
// - long frame bits 15..8 are input states 8..1, input 8 first
// - low byte: undervoltage, overtemperature, parity 1..4, stop low, high
// - undervoltage alarm low below on threshold, high above off threshold
// - overtemperature alarm low above on threshold, high below off one
// - four exclusive-nor parity bits sit in control bits 5 down to 2
// - without bus supply data-out is held low during any transfer
// - power-loss reset asserts on low bus or low logic supply
// - chip select high releases both data-out pins to high impedance
// - powered and selected, complement pin drives inverse of data-out
// - power loss and selected: data-out low, complement high
`include "serializer_defines.svh"

module digital_input_spi_serializer #(
  parameter int                         FIFO_DEPTH   = 32,
  parameter logic [4*`PARITY_SRC_W-1:0] PARITY_MASKS =
    {10'h2ab, 10'h1b3, 10'h0f8, 10'h307}
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  // spi pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe_n,
  output logic            miso_n,
  output logic            miso_n_oe_n,
  // static frame length select
  input  wire logic       frame_length_select_pin,
  // analog comparator levels
  input  wire logic       bus_below_on,
  input  wire logic       bus_above_off,
  input  wire logic       temp_above_on,
  input  wire logic       temp_below_off,
  input  wire logic       bus_below_por,
  input  wire logic       vdd_below_por,
  // filtered input snapshots
  input  wire logic [7:0] input_states,
  input  wire logic       input_valid,
  output logic            input_ready,
  // word shifted in from the master
  output logic [15:0]     rx_word,
  output logic            rx_valid,
  // status
  output logic            bus_undervoltage_alarm_n,
  output logic            overtemperature_alarm_n,
  output logic            power_good
);

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("digital_input_spi_serializer: fifo depth too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  serializer_pkg::pin_bundle_t pins_raw;
  serializer_pkg::pin_bundle_t sync1_reg;
  serializer_pkg::pin_bundle_t sync2_reg;
  serializer_pkg::pin_bundle_t sync_next;
  logic                        cs_prev_reg;
  logic                        cs_prev_next;
  logic                        sck_prev_reg;
  logic                        sck_prev_next;

  always_comb begin
    pins_raw.cs_n                    = cs_n;
    pins_raw.sck                     = sck;
    pins_raw.mosi                    = mosi;
    pins_raw.frame_length_select_pin = frame_length_select_pin;
    pins_raw.bus_below_on            = bus_below_on;
    pins_raw.bus_above_off           = bus_above_off;
    pins_raw.temp_above_on           = temp_above_on;
    pins_raw.temp_below_off          = temp_below_off;
    pins_raw.bus_below_por           = bus_below_por;
    pins_raw.vdd_below_por           = vdd_below_por;
    pins_raw.input_states            = input_states;
    sync_next                        = sync1_reg;
    cs_prev_next                     = sync2_reg.cs_n;
    sck_prev_next                    = sync2_reg.sck;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_reg    <= '{cs_n: 1'b1, default: '0};
      sync2_reg    <= '{cs_n: 1'b1, default: '0};
      cs_prev_reg  <= 1'b1;
      sck_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= pins_raw;
      sync2_reg    <= sync_next;
      cs_prev_reg  <= cs_prev_next;
      sck_prev_reg <= sck_prev_next;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic por_n;

  assign cs_fall  = cs_prev_reg && !sync2_reg.cs_n;
  assign cs_rise  = !cs_prev_reg && sync2_reg.cs_n;
  assign sck_rise = !sck_prev_reg && sync2_reg.sck;
  assign sck_fall = sck_prev_reg && !sync2_reg.sck;
  assign por_n    = !(sync2_reg.bus_below_por
                   || sync2_reg.vdd_below_por);

  ////////////////////////////////////////////////////////////////////////////
  // supply and temperature alarms with hysteresis
  logic uva_n_reg;
  logic uva_n_next;
  logic ota_n_reg;
  logic ota_n_next;
  logic good_next;

  always_comb begin
    uva_n_next = uva_n_reg;
    if (sync2_reg.bus_below_on) begin
      uva_n_next = 1'b0;
    end else if (sync2_reg.bus_above_off) begin
      uva_n_next = 1'b1;
    end
    ota_n_next = ota_n_reg;
    if (sync2_reg.temp_above_on) begin
      ota_n_next = 1'b0;
    end else if (sync2_reg.temp_below_off) begin
      ota_n_next = 1'b1;
    end
    good_next = por_n;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      uva_n_reg  <= `ALARM_RESET_N;
      ota_n_reg  <= `ALARM_RESET_N;
      power_good <= 1'b0;
    end else begin
      uva_n_reg  <= uva_n_next;
      ota_n_reg  <= ota_n_next;
      power_good <= good_next;
    end
  end

  assign bus_undervoltage_alarm_n = uva_n_reg;
  assign overtemperature_alarm_n  = ota_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // snapshot fifo
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_pop;

  sample_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_data   (input_states),
    .in_valid  (input_valid),
    .in_ready  (input_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame assembly
  logic [7:0]                  states_reg;
  logic [7:0]                  states_now;
  logic [`PARITY_SRC_W-1:0]    parity_src;
  logic [`PARITY_CNT-1:0]      parity;
  serializer_pkg::frame_word_t frame;

  always_comb begin
    states_now = fifo_valid ? fifo_data : states_reg;
    parity_src = {states_now, uva_n_reg, ota_n_reg};
    for (int i = 0; i < `PARITY_CNT; i++) begin
      parity[`PARITY_CNT-1-i] = ~^(parity_src
        & PARITY_MASKS[(`PARITY_CNT-1-i)*`PARITY_SRC_W +: `PARITY_SRC_W]);
    end
    frame.input_states             = states_now;
    frame.bus_undervoltage_alarm_n = uva_n_reg;
    frame.overtemperature_alarm_n  = ota_n_reg;
    frame.parity                   = parity;
    frame.stop_low                 = `STOP_LOW_VAL;
    frame.stop_high                = `STOP_HIGH_VAL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link state machine
  serializer_pkg::link_state_t state_reg;
  serializer_pkg::link_state_t state_next;
  logic [15:0]                 shift_reg;
  logic [15:0]                 shift_next;
  logic [15:0]                 rxsh_reg;
  logic [15:0]                 rxsh_next;
  logic                        mosi_cap_reg;
  logic                        mosi_cap_next;
  logic [`BIT_CNT_W-1:0]       cnt_reg;
  logic [`BIT_CNT_W-1:0]       cnt_next;
  logic [`BIT_CNT_W-1:0]       len_reg;
  logic [`BIT_CNT_W-1:0]       len_next;
  logic [7:0]                  states_next;
  logic [15:0]                 rx_word_next;
  logic                        rx_valid_next;

  always_comb begin
    state_next    = state_reg;
    shift_next    = shift_reg;
    rxsh_next     = rxsh_reg;
    mosi_cap_next = mosi_cap_reg;
    cnt_next      = cnt_reg;
    len_next      = len_reg;
    states_next   = states_reg;
    rx_word_next  = rx_word;
    rx_valid_next = 1'b0;
    fifo_pop      = 1'b0;
    unique case (state_reg)
      serializer_pkg::LINK_IDLE: begin
        if (cs_fall) begin
          state_next  = serializer_pkg::LINK_ACTIVE;
          fifo_pop    = fifo_valid;
          states_next = states_now;
          cnt_next    = '0;
          if (sync2_reg.frame_length_select_pin
              == `LONG_FRAME_LEVEL) begin
            len_next   = `FRAME_LEN_LONG;
            shift_next = frame;
          end else begin
            len_next   = `FRAME_LEN_SHORT;
            shift_next = {states_now, `STATES_RESET};
          end
        end
      end
      serializer_pkg::LINK_ACTIVE: begin
        if (cs_rise) begin
          state_next = serializer_pkg::LINK_IDLE;
          if (cnt_reg == len_reg) begin
            rx_word_next  = rxsh_reg;
            rx_valid_next = 1'b1;
          end
        end else begin
          if (sck_rise) begin
            mosi_cap_next = sync2_reg.mosi;
            rxsh_next     = {rxsh_reg[14:0], sync2_reg.mosi};
            if (cnt_reg != `FRAME_LEN_LONG) begin
              cnt_next = cnt_reg + 1'b1;
            end
          end
          if (sck_fall) begin
            shift_next = {shift_reg[14:0], mosi_cap_reg};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= serializer_pkg::LINK_IDLE;
      shift_reg    <= `WORD_RESET;
      rxsh_reg     <= `WORD_RESET;
      mosi_cap_reg <= 1'b0;
      cnt_reg      <= '0;
      len_reg      <= `FRAME_LEN_LONG;
      states_reg   <= `STATES_RESET;
      rx_word      <= `WORD_RESET;
      rx_valid     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      rxsh_reg     <= rxsh_next;
      mosi_cap_reg <= mosi_cap_next;
      cnt_reg      <= cnt_next;
      len_reg      <= len_next;
      states_reg   <= states_next;
      rx_word      <= rx_word_next;
      rx_valid     <= rx_valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drivers, registered from next state
  serializer_pkg::out_drive_t drive_next;

  always_comb begin
    drive_next.miso        = 1'b0;
    drive_next.miso_n      = 1'b1;
    drive_next.miso_oe_n   = 1'b1;
    drive_next.miso_n_oe_n = 1'b1;
    if (state_next == serializer_pkg::LINK_ACTIVE) begin
      drive_next.miso_oe_n   = 1'b0;
      drive_next.miso_n_oe_n = 1'b0;
      if (por_n) begin
        drive_next.miso   = shift_next[`POS_STATES_HI];
        drive_next.miso_n = !shift_next[`POS_STATES_HI];
      end else begin
        drive_next.miso   = 1'b0;
        drive_next.miso_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      miso        <= 1'b0;
      miso_n      <= 1'b1;
      miso_oe_n   <= 1'b1;
      miso_n_oe_n <= 1'b1;
    end else begin
      miso        <= drive_next.miso;
      miso_n      <= drive_next.miso_n;
      miso_oe_n   <= drive_next.miso_oe_n;
      miso_n_oe_n <= drive_next.miso_n_oe_n;
    end
  end

endmodule

// *** bench/serializer_chk.sv ***
module serializer_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_n,
  input wire logic miso_n_oe_n,
  input wire logic bus_below_on,
  input wire logic bus_above_off,
  input wire logic temp_above_on,
  input wire logic bus_below_por,
  input wire logic vdd_below_por,
  input wire logic rx_valid,
  input wire logic bus_undervoltage_alarm_n,
  input wire logic overtemperature_alarm_n,
  input wire logic power_good
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence cs_opened;
    $fell(cs_n) ##1 !cs_n [*5];
  endsequence

  sequence lost_driving;
    !power_good [*4] ##0 !miso_oe_n;
  endsequence

  oe_pair_a: assert property (miso_oe_n == miso_n_oe_n)
    else $error("output enables differ");
  idle_release_a: assert property (cs_n [*6] |-> miso_oe_n)
    else $error("data-out driven while deselected");
  open_drive_a: assert property (cs_opened |-> !miso_oe_n)
    else $error("data-out not driven after select");
  complement_a: assert property (!miso_oe_n |-> miso_n == !miso)
    else $error("complement pin not inverse");
  loss_low_a: assert property (lost_driving |-> !miso)
    else $error("data-out high during power loss");
  pg_loss_a: assert property ((bus_below_por || vdd_below_por) [*4]
    |-> !power_good)
    else $error("power good despite low supply");
  uva_set_a: assert property (bus_below_on [*4] |->
    !bus_undervoltage_alarm_n)
    else $error("undervoltage alarm not raised");
  uva_hold_a: assert property (!bus_above_off [*4]
    ##0 !bus_undervoltage_alarm_n |=> !bus_undervoltage_alarm_n)
    else $error("undervoltage alarm left early");
  ota_set_a: assert property (temp_above_on [*4] |->
    !overtemperature_alarm_n)
    else $error("overtemperature alarm not raised");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("receive pulse too long");
  rx_end_a: assert property (rx_valid |-> cs_n && $past(cs_n, 2))
    else $error("receive pulse inside frame");
endmodule

// *** bench/spi_master_model.sv ***
module spi_master_model (
  input  wire logic miso,
  input  wire logic miso_oe_n,
  output logic      cs_n,
  output logic      sck,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  logic power_lost;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
    power_lost = 1'b0;
  end

  // sck stands low between frames; released miso reads as inverse bit
  task automatic transfer(input int n, input logic [15:0] tx,
                          output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    mosi = tx[n - 1];
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      #100 sck = 1'b1;
      rx = {rx[14:0], miso_oe_n ? ~miso : miso};
      #60 sck = 1'b0;
      mosi = (i > 0) ? tx[i - 1] : ~tx[0];
    end
    #160 cs_n = 1'b1;
    power_lost = (rx[0] === 1'b0);
  endtask
endmodule

// *** bench/digital_input_spi_serializer_bench.sv ***
module digital_input_spi_serializer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [39:0] MASKS = {10'h3ff, 10'h201, 10'h0c3, 10'h155};
  logic        clock, resetn, cs_n, sck, mosi, miso, miso_oe_n, miso_n;
  logic        miso_n_oe_n, frame_length_select_pin, input_valid;
  logic        input_ready, bus_below_on, bus_above_off, temp_above_on;
  logic        temp_below_off, bus_below_por, vdd_below_por, rx_valid;
  logic        power_good, bus_undervoltage_alarm_n, overtemperature_alarm_n;
  logic [7:0]  input_states;
  logic [15:0] rx_word, rx;
  int          n_errors = 0;
  int          n_tests = 0;

  digital_input_spi_serializer #(.PARITY_MASKS(MASKS))
    digital_input_spi_serializer_i (
    .clock                    (clock),
    .resetn                   (resetn),
    .cs_n                     (cs_n),
    .sck                      (sck),
    .mosi                     (mosi),
    .miso                     (miso),
    .miso_oe_n                (miso_oe_n),
    .miso_n                   (miso_n),
    .miso_n_oe_n              (miso_n_oe_n),
    .frame_length_select_pin  (frame_length_select_pin),
    .bus_below_on             (bus_below_on),
    .bus_above_off            (bus_above_off),
    .temp_above_on            (temp_above_on),
    .temp_below_off           (temp_below_off),
    .bus_below_por            (bus_below_por),
    .vdd_below_por            (vdd_below_por),
    .input_states             (input_states),
    .input_valid              (input_valid),
    .input_ready              (input_ready),
    .rx_word                  (rx_word),
    .rx_valid                 (rx_valid),
    .bus_undervoltage_alarm_n (bus_undervoltage_alarm_n),
    .overtemperature_alarm_n  (overtemperature_alarm_n),
    .power_good               (power_good)
  );
  spi_master_model spi_master_model_i (
    .miso      (miso),
    .miso_oe_n (miso_oe_n),
    .cs_n      (cs_n),
    .sck       (sck),
    .mosi      (mosi)
  );

  always #10 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #3;
  endtask

  task automatic push(input logic [7:0] d);
    input_states = d;
    input_valid = 1'b1;
    tick(1);
    input_valid = 1'b0;
  endtask

  function automatic logic [15:0] word(input logic [7:0] s,
                                       input logic u, o);
    logic [9:0] src;
    logic [3:0] pc;
    src = {s, u, o};
    for (int i = 0; i < 4; i++) pc[3 - i] = ~^(src & MASKS[39 - 10*i -: 10]);
    return {s, u, o, pc, 1'b0, 1'b1};
  endfunction

  task automatic frame(input int n, input logic [15:0] tx, exp);
    int          k;
    logic [15:0] m;
    m = (n == 16) ? 16'hffff : 16'h00ff;
    spi_master_model_i.transfer(n, tx, rx);
    check(rx, exp, "frame out");
    k = 0;
    if (power_good === 1'b1) begin
      while (rx_valid !== 1'b1 && k < 20) begin
        tick(1);
        k++;
      end
      if (k == 20) begin
        n_errors++;
        complete_run();
      end
      check(rx_word & m, tx & m, "frame in");
    end
    tick(2);
  endtask

  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    input_valid = 1'b0;
    input_states = 8'h00;
    frame_length_select_pin = 1'b0;
    {bus_below_on, bus_above_off, temp_above_on} = 3'b010;
    {temp_below_off, bus_below_por, vdd_below_por} = 3'b100;
    tick(10);
    check({miso_oe_n, input_ready, power_good}, 16'h0006, "reset");
    resetn = 1'b1;
    tick(4);
    check({bus_undervoltage_alarm_n, overtemperature_alarm_n}, 16'h3, "al");
    push(8'ha5);
    frame(16, 16'h3c5a, word(8'ha5, 1'b1, 1'b1));
    frame(16, 16'hc3a5, word(8'ha5, 1'b1, 1'b1));
    {bus_below_on, bus_above_off, temp_above_on, temp_below_off} = 4'b1010;
    tick(4);
    {bus_below_on, temp_above_on} = 2'b00;
    tick(4);
    push(8'h5c);
    frame(16, 16'h0ff0, word(8'h5c, 1'b0, 1'b0));
    {bus_above_off, temp_below_off} = 2'b11;
    tick(4);
    frame(16, 16'hffff, word(8'h5c, 1'b1, 1'b1));
    for (int i = 0; i < 2; i++) begin
      {bus_below_por, vdd_below_por} = i ? 2'b01 : 2'b10;
      tick(5);
      check(power_good, 16'h0, "power loss");
      frame(16, 16'h1234, 16'h0000);
      check(spi_master_model_i.power_lost, 16'h1, "stop bit");
    end
    {bus_below_por, vdd_below_por} = 2'b00;
    frame_length_select_pin = 1'b1;
    input_valid = 1'b1;
    for (int i = 0; i < 33; i++) begin
      input_states = 8'(i * 7 + 1);
      tick(1);
    end
    input_valid = 1'b0;
    check(power_good, 16'h1, "power back");
    check(input_ready, 16'h0, "fifo full");
    for (int i = 0; i < 32; i++)
      frame(8, 16'(i + 8'h40), {8'h00, 8'(i * 7 + 1)});
    frame(8, 16'h00aa, 16'h00da);
    check(input_ready, 16'h1, "fifo drained");
    complete_run();
  end
endmodule

bind digital_input_spi_serializer serializer_chk serializer_chk_i (
  .clock                    (clock),
  .resetn                   (resetn),
  .cs_n                     (cs_n),
  .miso                     (miso),
  .miso_oe_n                (miso_oe_n),
  .miso_n                   (miso_n),
  .miso_n_oe_n              (miso_n_oe_n),
  .bus_below_on             (bus_below_on),
  .bus_above_off            (bus_above_off),
  .temp_above_on            (temp_above_on),
  .bus_below_por            (bus_below_por),
  .vdd_below_por            (vdd_below_por),
  .rx_valid                 (rx_valid),
  .bus_undervoltage_alarm_n (bus_undervoltage_alarm_n),
  .overtemperature_alarm_n  (overtemperature_alarm_n),
  .power_good               (power_good)
);
